// ### rtl/dac_mode_pkg.sv
// Package with register map, field layout and reset values of the mode-control bank.
package dac_mode_pkg;

    // Register indices as printed; byte address is four times the index.
    localparam logic [6:0] IDX_DEEMPH     = 7'h13;
    localparam logic [6:0] IDX_FMT_FILTER = 7'h14;
    localparam logic [6:0] IDX_ATTEN_MODE = 7'h15;
    localparam logic [6:0] IDX_PHASE_ZERO = 7'h16;
    localparam logic [6:0] IDX_SOFT_RESET = 7'h12;
    localparam logic [6:0] IDX_STATUS     = 7'h17;

    // Word layout of a control word.
    localparam int CW_IDX_LSB = 8;
    localparam int CW_IDX_MSB = 14;
    localparam int CW_TOP     = 15;

    // Field positions in the data byte.
    localparam int POS_DEEMPH_EN  = 4;
    localparam int POS_DEEMPH_LSB = 5;
    localparam int POS_FMT_LSB    = 0;
    localparam int POS_ROLLOFF    = 5;
    localparam int POS_ATTEN_MODE = 0;
    localparam int POS_PHASE_INV  = 0;
    localparam int POS_ZERO_POL   = 1;
    localparam int POS_ZERO_ASGN  = 2;
    localparam int POS_SOFT_RST   = 7;

    // Reset values.
    localparam logic       RST_DEEMPH_EN = 1'b0;
    localparam logic [1:0] RST_DEEMPH_RATE = 2'h0;
    localparam logic [2:0] RST_FMT       = 3'h5;
    localparam logic       RST_BIT       = 1'b0;

    // Soft reset hold time in system clocks.
    localparam logic [10:0] SOFT_RST_CYCLES = 11'h400;

    // Decoded audio format.
    typedef enum logic [2:0] {
        FMT_RJ24 = 3'h0,
        FMT_RJ20 = 3'h1,
        FMT_RJ18 = 3'h2,
        FMT_RJ16 = 3'h3,
        FMT_I2S  = 3'h4,
        FMT_LJ   = 3'h5
    } audio_fmt_e;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Attenuator step in half-dB units and lowest code before mute.
    localparam logic [1:0] STEP_FINE  = 2'h1;
    localparam logic [1:0] STEP_WIDE  = 2'h2;
    localparam logic [7:0] FLOOR_FINE = 8'h81;
    localparam logic [7:0] FLOOR_WIDE = 8'h9B;

endpackage

// ### rtl/audio_dac_mode_control_regs.sv
// Mode-control register bank of the stereo audio DAC with an AXI4-Lite slave.
//
// What this block does
// - De-emphasis enable bit, resets to zero.
// - Rate field: 44.1, 48, 32 kHz, 11 reserved.
// - Rate field matters only while de-emphasis enabled.
// - Formats 000..011: right-justified 24/20/18/16 bits.
// - 100 I2S, 101 left-justified default, rest reserved.
// - Rolloff bit: 0 sharp, 1 slow.
// - Mode 0: fine 0.5 dB steps to -63 dB.
// - Mode 1: wide 1 dB steps to -100 dB.
// - Phase bit 1 inverts analog output polarity.
// - Polarity bit 0 flags high, 1 low.
// - Assign bit: separate flags, or one combined.
// - Mode step also applies to soft-mute ramps.
`timescale 1ns/1ns
`default_nettype none
module audio_dac_mode_control_regs
    import dac_mode_pkg::*;
(
    // Clock and reset.
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address channel.
    input  wire logic [8:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data channel.
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response channel.
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address channel.
    input  wire logic [8:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data channel.
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Zero detectors from the audio datapath, same clock.
    input  wire logic        left_zero_det,
    input  wire logic        right_zero_det,
    // Mode controls to the audio datapath.
    output logic             deemph_active,
    output logic [1:0]       deemph_rate_sel,
    output logic [2:0]       audio_format_sel,
    output logic [4:0]       audio_word_bits,
    output logic             filter_rolloff_sel,
    output logic             atten_step_mode,
    output logic [1:0]       atten_step_half_db,
    output logic [7:0]       atten_floor_code,
    output logic             output_phase_invert,
    output logic             soft_reset_active,
    // Zero-flag pins.
    output logic             left_zero_flag,
    output logic             right_zero_flag
);

    // Stored fields.
    logic        deemph_en_reg;
    logic [1:0]  deemph_rate_reg;
    logic [2:0]  fmt_reg;
    logic        rolloff_reg;
    logic        atten_mode_reg;
    logic        phase_inv_reg;
    logic        zero_pol_reg;
    logic        zero_asgn_reg;
    logic [10:0] srst_cnt_reg;
    logic [10:0] srst_cnt_next;

    // Write channel capture.
    logic        aw_held_reg;
    logic [6:0]  aw_idx_reg;
    logic        w_held_reg;
    logic [15:0] w_word_reg;
    logic        w_lane_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;

    // Read channel state.
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;

    // Zero-flag pin registers.
    logic        left_flag_reg;
    logic        right_flag_reg;

    // Index of a word address; low two address bits are ignored.
    function automatic logic [6:0] addr_index(input logic [8:0] addr);
        return addr[8:2];
    endfunction

    // True when an index names a register that exists.
    function automatic logic idx_mapped(input logic [6:0] idx);
        return (idx == IDX_DEEMPH) || (idx == IDX_FMT_FILTER) || (idx == IDX_ATTEN_MODE) ||
               (idx == IDX_PHASE_ZERO) || (idx == IDX_SOFT_RESET) || (idx == IDX_STATUS);
    endfunction

    // Handshake decode: address and data may arrive in either order.
    // Each beat is held until both are present; the write then lands in one edge.
    wire        aw_take = s_axi_awvalid & s_axi_awready;
    wire        w_take  = s_axi_wvalid & s_axi_wready;
    wire        do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
    wire        ar_take = s_axi_arvalid & s_axi_arready;
    // The control word: index carried by the address, data byte on lane 0.
    wire [6:0]  wr_idx  = aw_idx_reg;
    wire [7:0]  wr_data = w_word_reg[7:0];
    // A word must have its top bit clear and lane 0 enabled to be applied.
    wire        word_ok = ~w_word_reg[CW_TOP] & w_lane_reg;
    // Status and read-only registers refuse writes.
    wire        wr_store = do_write & word_ok & idx_mapped(wr_idx) & (wr_idx != IDX_STATUS);
    // Per-register write enables, one index each.
    wire        we_deemph = wr_store & (wr_idx == IDX_DEEMPH);
    wire        we_fmt    = wr_store & (wr_idx == IDX_FMT_FILTER);
    wire        we_atten  = wr_store & (wr_idx == IDX_ATTEN_MODE);
    wire        we_phase  = wr_store & (wr_idx == IDX_PHASE_ZERO);
    wire        we_srst   = wr_store & (wr_idx == IDX_SOFT_RESET) & wr_data[POS_SOFT_RST];
    wire        srst_busy = (srst_cnt_reg != 11'h000);
    // Reserved format codes are ignored and the previous format kept.
    wire        fmt_legal = (wr_data[POS_FMT_LSB +: 3] <= 3'h5);
    // Reserved rate code 11 is ignored.
    wire        rate_legal = (wr_data[POS_DEEMPH_LSB +: 2] != 2'h3);

    // Readies drop while a beat is held; valids and payloads come from flip-flops.
    assign s_axi_awready = ~aw_held_reg;
    assign s_axi_wready  = ~w_held_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // Soft reset counter: loaded by a write, counts down, clears fields while running.
    // A further soft reset write while one runs restarts the full span.
    assign srst_cnt_next = we_srst ? SOFT_RST_CYCLES :
                           (srst_busy ? srst_cnt_reg - 11'h001 : srst_cnt_reg);

    // Write address and data holding registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_idx_reg  <= 7'h00;
            w_held_reg  <= 1'b0;
            w_word_reg  <= 16'h0000;
            w_lane_reg  <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_held_reg <= 1'b1;
                aw_idx_reg  <= addr_index(s_axi_awaddr);
            end else if (do_write) begin
                aw_held_reg <= 1'b0;
            end
            if (w_take) begin
                w_held_reg <= 1'b1;
                w_word_reg <= s_axi_wdata[15:0];
                w_lane_reg <= s_axi_wstrb[0];
            end else if (do_write) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // Write response: OKAY for a mapped writable index, SLVERR otherwise.
    // The answer rises on the edge that applies the write and stands until bready.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (idx_mapped(wr_idx) && wr_idx != IDX_STATUS) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Mode fields; bus reset or a running soft reset restores defaults.
    always_ff @(posedge aclk) begin
        if (!aresetn || srst_busy) begin
            deemph_en_reg   <= RST_DEEMPH_EN;
            deemph_rate_reg <= RST_DEEMPH_RATE;
            fmt_reg         <= RST_FMT;
            rolloff_reg     <= RST_BIT;
            atten_mode_reg  <= RST_BIT;
            phase_inv_reg   <= RST_BIT;
            zero_pol_reg    <= RST_BIT;
            zero_asgn_reg   <= RST_BIT;
        end else begin
            if (we_deemph) begin
                deemph_en_reg <= wr_data[POS_DEEMPH_EN];
                if (rate_legal) begin
                    deemph_rate_reg <= wr_data[POS_DEEMPH_LSB +: 2];
                end
            end
            if (we_fmt) begin
                rolloff_reg <= wr_data[POS_ROLLOFF];
                if (fmt_legal) begin
                    fmt_reg <= wr_data[POS_FMT_LSB +: 3];
                end
            end
            if (we_atten) begin
                atten_mode_reg <= wr_data[POS_ATTEN_MODE];
            end
            if (we_phase) begin
                phase_inv_reg <= wr_data[POS_PHASE_INV];
                zero_pol_reg  <= wr_data[POS_ZERO_POL];
                zero_asgn_reg <= wr_data[POS_ZERO_ASGN];
            end
        end
    end

    // Soft reset counter register.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            srst_cnt_reg <= 11'h000;
        end else begin
            srst_cnt_reg <= srst_cnt_next;
        end
    end

    // Read mux: fields in their written positions, reserved bits zero.
    wire [6:0]  rd_idx = addr_index(s_axi_araddr);
    wire [7:0]  rd_deemph = {1'b0, deemph_rate_reg, deemph_en_reg, 4'h0};
    wire [7:0]  rd_fmt    = {2'h0, rolloff_reg, 2'h0, fmt_reg};
    wire [7:0]  rd_atten  = {7'h00, atten_mode_reg};
    wire [7:0]  rd_phase  = {5'h00, zero_asgn_reg, zero_pol_reg, phase_inv_reg};
    wire [7:0]  rd_srst   = {srst_busy, 7'h00};
    wire [7:0]  rd_status = {6'h00, right_zero_det, left_zero_det};
    wire [7:0]  rd_byte = (rd_idx == IDX_DEEMPH)     ? rd_deemph :
                          (rd_idx == IDX_FMT_FILTER) ? rd_fmt :
                          (rd_idx == IDX_ATTEN_MODE) ? rd_atten :
                          (rd_idx == IDX_PHASE_ZERO) ? rd_phase :
                          (rd_idx == IDX_SOFT_RESET) ? rd_srst :
                          (rd_idx == IDX_STATUS)     ? rd_status : 8'h00;

    // Read data channel, answered the cycle after the address is taken.
    // Unmapped indices read as zero with an error response.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= {24'h00_0000, rd_byte};
            rresp_reg  <= idx_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // Controls to the datapath.
    assign deemph_active       = deemph_en_reg;
    // Rate is forced to the default code while de-emphasis is off.
    assign deemph_rate_sel     = deemph_en_reg ? deemph_rate_reg : RST_DEEMPH_RATE;
    assign audio_format_sel    = fmt_reg;
    // Right-justified word length; I2S and left-justified modes report 24 as the maximum.
    assign audio_word_bits     = (fmt_reg == FMT_RJ20) ? 5'h14 :
                                 (fmt_reg == FMT_RJ18) ? 5'h12 :
                                 (fmt_reg == FMT_RJ16) ? 5'h10 : 5'h18;
    assign filter_rolloff_sel  = rolloff_reg;
    assign atten_step_mode     = atten_mode_reg;
    // Step and floor for both level changes and mute ramps.
    assign atten_step_half_db  = atten_mode_reg ? STEP_WIDE : STEP_FINE;
    assign atten_floor_code    = atten_mode_reg ? FLOOR_WIDE : FLOOR_FINE;
    assign output_phase_invert = phase_inv_reg;
    assign soft_reset_active   = srst_busy;

    // Zero-flag routing: separate or combined, then polarity.
    wire both_zero = left_zero_det & right_zero_det;
    wire left_raw  = zero_asgn_reg ? 1'b0 : left_zero_det;
    wire right_raw = zero_asgn_reg ? both_zero : right_zero_det;

    // Flag pins are registered; the unassigned pin idles at its inactive level.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            left_flag_reg  <= 1'b0;
            right_flag_reg <= 1'b0;
        end else begin
            left_flag_reg  <= left_raw ^ zero_pol_reg;
            right_flag_reg <= right_raw ^ zero_pol_reg;
        end
    end

    // Pins come straight from flip-flops so a detector edge cannot glitch them.
    assign left_zero_flag  = left_flag_reg;
    assign right_zero_flag = right_flag_reg;

endmodule
`default_nettype wire

// ### verification/dac_mode_assertions.sv
// Checker of the mode-control outputs and the register bus handshakes.
`timescale 1ns/1ns
`default_nettype none
module dac_mode_checker
    import dac_mode_pkg::*;
(
    // Clock, reset and bus.
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Mode controls.
    input wire logic        deemph_active,
    input wire logic [1:0]  deemph_rate_sel,
    input wire logic [2:0]  audio_format_sel,
    input wire logic [4:0]  audio_word_bits,
    input wire logic        filter_rolloff_sel,
    input wire logic        atten_step_mode,
    input wire logic [1:0]  atten_step_half_db,
    input wire logic [7:0]  atten_floor_code,
    input wire logic        output_phase_invert,
    input wire logic        soft_reset_active
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Steps of a write and of a read request.
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_WR_ANSWER: assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response missing");
    AST_RD_ANSWER: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data missing");
    AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_RATE_GATE: assert property (!deemph_active |-> deemph_rate_sel == 2'h0)
        else $error("rate active while de-emphasis off");
    AST_RATE_CODE: assert property (deemph_rate_sel != 2'h3)
        else $error("reserved rate code applied");
    AST_FMT_CODE: assert property (audio_format_sel <= 3'h5)
        else $error("reserved format code applied");
    AST_WORD_BITS: assert property (audio_word_bits ==
        ((audio_format_sel == 3'h1) ? 5'h14 : (audio_format_sel == 3'h2) ? 5'h12 :
        (audio_format_sel == 3'h3) ? 5'h10 : 5'h18))
        else $error("word length does not match format");
    AST_FINE: assert property (!atten_step_mode |->
        atten_step_half_db == 2'h1 && atten_floor_code == 8'h81)
        else $error("fine attenuation step wrong");
    AST_WIDE: assert property (atten_step_mode |->
        atten_step_half_db == 2'h2 && atten_floor_code == 8'h9B)
        else $error("wide attenuation step wrong");
    AST_SOFT_DEFAULT: assert property (
        soft_reset_active && $past(soft_reset_active) |->
        audio_format_sel == 3'h5 && !deemph_active && !atten_step_mode && !output_phase_invert)
        else $error("field left its default during soft reset");
    AST_FIELD_CAUSE: assert property (
        $changed(output_phase_invert) || $changed(filter_rolloff_sel) |->
        $rose(s_axi_bvalid) || soft_reset_active || $past(soft_reset_active))
        else $error("field changed without a write");
endmodule
bind audio_dac_mode_control_regs dac_mode_checker chk_u (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .deemph_active, .deemph_rate_sel, .audio_format_sel, .audio_word_bits, .filter_rolloff_sel,
    .atten_step_mode, .atten_step_half_db, .atten_floor_code, .output_phase_invert,
    .soft_reset_active
);
`default_nettype wire

// ### verification/zero_det_source.sv
// Zero-detector source standing in for the audio datapath.
`timescale 1ns/1ns
`default_nettype none
module zero_det_source (
    // Clock and reset.
    input  wire logic aclk,
    input  wire logic aresetn,
    // Requested detector levels.
    input  wire logic left_req,
    input  wire logic right_req,
    // Detector levels, one clock behind the request.
    output logic      left_zero_det,
    output logic      right_zero_det
);
    // The datapath registers its detectors, so a level follows one clock later.
    always_ff @(posedge aclk) begin
        left_zero_det  <= aresetn & left_req;
        right_zero_det <= aresetn & right_req;
    end
endmodule
`default_nettype wire

// ### verification/audio_dac_mode_control_regs_bench.sv
// Self-checking bench of the mode-control register bank.
`timescale 1ns/1ns
`default_nettype none
module audio_dac_mode_control_regs_bench
    import dac_mode_pkg::*;
;
    // Drive, design outputs, model fields and bookkeeping.
    logic        aclk = 1'b0, aresetn = 1'b0, lreq = 1'b0, rreq = 1'b0;
    logic [8:0]  awaddr = 9'h0, araddr = 9'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'hF;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, ldet, rdet, lflag, rflag;
    logic        den, roll, mode, phase, srst, m_en, m_roll, m_mode;
    logic [1:0]  bresp, rresp, rate, step, m_rate;
    logic [2:0]  fmt, m_fmt, m_pzr;
    logic [4:0]  wbits;
    logic [7:0]  floor_c;
    logic [7:0]  mask [4] = '{8'h70, 8'h27, 8'h01, 8'h07};
    int          n_mismatch = 0, total_checks = 0, seed = 65, j;
    audio_dac_mode_control_regs dut_u (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .left_zero_det(ldet),
        .right_zero_det(rdet), .deemph_active(den), .deemph_rate_sel(rate),
        .audio_format_sel(fmt), .audio_word_bits(wbits), .filter_rolloff_sel(roll),
        .atten_step_mode(mode), .atten_step_half_db(step), .atten_floor_code(floor_c),
        .output_phase_invert(phase), .soft_reset_active(srst), .left_zero_flag(lflag),
        .right_zero_flag(rflag)
    );
    zero_det_source det_u (.aclk(aclk), .aresetn(aresetn), .left_req(lreq), .right_req(rreq),
        .left_zero_det(ldet), .right_zero_det(rdet));
    // Clock at 250 MHz.
    initial begin
        forever #2 aclk = ~aclk;
    end
    // Compares one result and counts it.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Puts the model fields at their reset values.
    task automatic mreset();
        {m_en, m_rate, m_fmt, m_roll, m_mode, m_pzr} = {6'h05, 5'h0};
    endtask
    // Expected read data of one index.
    function automatic logic [31:0] rexp(input logic [6:0] i);
        case (i)
            7'h13: return {25'h0, m_rate, m_en, 4'h0};
            7'h14: return {26'h0, m_roll, 2'h0, m_fmt};
            7'h15: return {31'h0, m_mode};
            7'h16: return {29'h0, m_pzr};
            7'h17: return {30'h0, rdet, ldet};
            default: return 32'h0;
        endcase
    endfunction
    // One write: both channels offered together, each held until taken.
    task automatic wr(input logic [6:0] i, input logic [31:0] d, input logic [3:0] s);
        logic ta, tw, tb;
        logic [1:0] r;
        awaddr <= {i, 2'h0};
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(negedge aclk);
            {ta, tw, tb, r} = {awready, wready, bvalid, bresp};
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!tb);
        chk("bresp", (i > 7'h11 && i < 7'h17) ? RESP_OKAY : RESP_SLVERR,
            {30'h0, r});
        if (s[0] && !d[15]) begin
            case (i)
                7'h12: if (d[7]) mreset();
                7'h13: {m_en, m_rate} = {d[4], (d[6:5] == 2'h3) ? m_rate : d[6:5]};
                7'h14: {m_roll, m_fmt} = {d[5], (d[2:0] > 3'h5) ? m_fmt : d[2:0]};
                7'h15: m_mode = d[0];
                7'h16: m_pzr = d[2:0];
                default: ;
            endcase
        end
    endtask
    // One read; ready is raised only after data has waited one edge.
    task automatic rd(input logic [6:0] i);
        logic t;
        araddr <= {i, 2'h0};
        arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            t = arready;
            @(posedge aclk);
        end while (!t);
        arvalid <= 1'b0;
        do begin
            @(negedge aclk);
            t = rvalid;
            @(posedge aclk);
        end while (!t);
        rready <= 1'b1;
        @(negedge aclk);
        chk("rdata", rexp(i), rdata);
        chk("rresp", (i > 7'h11 && i < 7'h18) ? RESP_OKAY : RESP_SLVERR,
            {30'h0, rresp});
        @(posedge aclk);
        rready <= 1'b0;
    endtask
    // Compares every mode output except soft_reset_active, then the phase and both flags, with the model.
    task automatic chk_out();
        logic [31:0] e;
        logic [4:0]  wb;
        @(negedge aclk);
        wb = (m_fmt == 3'h1) ? 5'h14 : (m_fmt == 3'h2) ? 5'h12 : (m_fmt == 3'h3) ? 5'h10 : 5'h18;
        e = {9'h0, m_en, m_en ? m_rate : 2'h0, m_fmt, wb, m_roll, m_mode};
        e = {e[21:0], m_mode ? 10'h29B : 10'h181};
        chk("modes", e,
            {9'h0, den, rate, fmt, wbits, roll, mode, step, floor_c});
        e = {ldet, rdet} ^ {2{m_pzr[1]}};
        if (m_pzr[2]) e = {m_pzr[1], (ldet & rdet) ^ m_pzr[1]};
        chk("flags", {29'h0, m_pzr[0], e[1:0]},
            {29'h0, phase, lflag, rflag});
        @(posedge aclk);
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
    // Main sequence.
    initial begin
        mreset();
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk_out();
        for (int i = 16; i < 25; i++) rd(i[6:0]);
        for (int c = 0; c < 8; c++) begin
            wr(7'h14, {26'h0, c[0], 2'h0, c[2:0]}, 4'hF);
            chk_out();
            wr(7'h13, {25'h0, c[1:0], c[2], 4'h0}, 4'hF);
            chk_out();
            rd(7'h13);
        end
        for (int k = 0; k < 24; k++) begin
            j = $random(seed) & 3;
            wr(7'h13 + j[6:0], {24'h0, 8'($random(seed)) & mask[j]}, 4'hF);
            chk_out();
            rd(7'h13 + j[6:0]);
        end
        wr(7'h15, 32'h0, 4'hF);
        wr(7'h15, 32'h0000_8001, 4'hF);
        wr(7'h15, 32'h1, 4'hE);
        wr(7'h17, 32'h3, 4'hF);
        wr(7'h30, 32'h1, 4'hF);
        chk_out();
        for (int c = 0; c < 32; c++) begin
            {rreq, lreq} <= c[4:3];
            wr(7'h16, {29'h0, c[2:0]}, 4'hF);
            repeat (2) @(posedge aclk);
            chk_out();
            rd(7'h17);
        end
        {rreq, lreq} <= 2'h0;
        wr(7'h14, 32'h24, 4'hF);
        wr(7'h12, 32'h80, 4'hF);
        j = 0;
        @(posedge aclk);
        do begin
            @(negedge aclk);
            j++;
        end while (srst === 1'b1 && j < 2000);
        // The wait opens two edges into the span, so one cycle less is counted.
        chk("soft reset span", {21'h0, SOFT_RST_CYCLES - 11'h001}, j);
        @(posedge aclk);
        chk_out();
        wr(7'h15, 32'h1, 4'hF);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        mreset();
        @(posedge aclk);
        chk_out();
        complete_run();
    end
endmodule
`default_nettype wire
